// File: host_port.v
`timescale 1ns/1ps
`include "host_port_consts.vh"
module host_port (
  input wire clk,
  input wire nrst,
  input wire chip_sel_n,
  input wire rd_n,
  input wire wr_n,
  input wire chan_sel,
  input wire ctrl_data_sel,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg data_oe,
  input wire irq_acknowledge_n,
  output reg irq_n_out,
  output reg irq_n_oe,
  input wire chain_enable_in,
  output reg chain_enable_out,
  input wire tx_empty_evt,
  input wire rx_avail,
  input wire error_evt,
  input wire status_evt,
  input wire [7:0] rx_char,
  output reg rx_read_pulse,
  output reg [7:0] tx_data,
  output reg tx_write_pulse,
  output reg chip_reset_out
);

  // ****************************************
  // strobe synchronisers
  // ****************************************
  reg [1:0] rd_sync_r;
  reg [1:0] wr_sync_r;
  reg [1:0] ack_sync_r;
  reg rd_seen_r;
  reg wr_seen_r;
  wire rd_act;
  wire wr_act;
  wire ack_act;
  wire rd_rise;
  wire wr_rise;
  wire both_act;

  // two flops per strobe, only stage two is used
  always @(posedge clk) begin
    if (!nrst) begin
      rd_sync_r <= 2'h0;
      wr_sync_r <= 2'h0;
      ack_sync_r <= 2'h0;
    end else begin
      rd_sync_r <= {rd_sync_r[0], ~rd_n};
      wr_sync_r <= {wr_sync_r[0], ~wr_n};
      ack_sync_r <= {ack_sync_r[0], ~irq_acknowledge_n};
    end
  end

  assign rd_act = rd_sync_r[1];
  assign wr_act = wr_sync_r[1];
  assign ack_act = ack_sync_r[1];
  assign both_act = rd_act & wr_act;
  assign rd_rise = rd_act & ~rd_seen_r & ~wr_act;
  assign wr_rise = wr_act & ~wr_seen_r & ~rd_act;

  // edge memory for single-action strobes
  always @(posedge clk) begin
    if (!nrst) begin
      rd_seen_r <= 1'b0;
      wr_seen_r <= 1'b0;
    end else begin
      rd_seen_r <= rd_act;
      wr_seen_r <= wr_act;
    end
  end

  // ****************************************
  // register select and control state
  // ****************************************
  wire [1:0] rsel;
  wire sel_ok;
  wire is_ctrl;
  wire [2:0] cmd;
  wire do_rd;
  wire do_wr;
  wire ack_rd;
  reg [7:0] vector_r;
  reg [2:0] ie_r;
  reg chain_dis_r;
  reg tx_pend_r;
  reg err_pend_r;
  reg st_pend_r;
  reg service_r;
  reg [2:0] ie_nxt;
  reg ack_seen_r;
  reg vec_won_r;
  reg tx_evt_hold_r;
  reg err_evt_hold_r;
  reg st_evt_hold_r;
  wire ctrl_wr;
  wire data_a_wr;
  wire cmd_tx_clr;
  wire cmd_srv_clr;
  wire cmd_chain_off;
  wire cmd_chain_on;
  wire cmd_err_clr;
  wire cmd_st_clr;
  wire ack_first;
  wire ack_win;
  wire tx_set;
  wire err_set;
  wire st_set;

  // register address from selects
  function [1:0] reg_index;
    input c_d;
    input a_b;
    begin
      reg_index = {c_d, a_b};
    end
  endfunction

  // command field match for one command code
  function cmd_is;
    input [2:0] code;
    input [2:0] want;
    begin
      cmd_is = (code == want);
    end
  endfunction

  assign rsel = reg_index(ctrl_data_sel, chan_sel);
  assign sel_ok = ~chip_sel_n;
  assign is_ctrl = ~rsel[1];
  assign cmd = data_in[`CMD_MSB:`CMD_LSB];
  assign do_rd = rd_rise & sel_ok & ~ack_act;
  assign do_wr = wr_rise & sel_ok & ~ack_act;
  assign ack_rd = ack_act & rd_act & ~wr_act;
  assign ack_first = ack_rd & ~ack_seen_r;

  // one strobe per command code on a control-register write
  assign ctrl_wr = do_wr & is_ctrl;
  assign data_a_wr = do_wr & (rsel == `RSEL_DATA_A);
  assign cmd_tx_clr = ctrl_wr & cmd_is(cmd, `CMD_RESET_TX_PEND);
  assign cmd_srv_clr = ctrl_wr & cmd_is(cmd, `CMD_CLEAR_SERVICE);
  assign cmd_chain_off = ctrl_wr & cmd_is(cmd, `CMD_CHAIN_DISABLE);
  assign cmd_chain_on = ctrl_wr & cmd_is(cmd, `CMD_CHAIN_ENABLE);
  assign cmd_err_clr = ctrl_wr & cmd_is(cmd, `CMD_CLEAR_ERROR);
  assign cmd_st_clr = ctrl_wr & cmd_is(cmd, `CMD_CLEAR_STATUS);

  // pending request, gated by enables
  wire rx_pend;
  wire any_pend;
  assign rx_pend = rx_avail & ie_r[1];
  assign any_pend = (tx_pend_r & ie_r[0]) | rx_pend |
                    ((err_pend_r | st_pend_r) & ie_r[2]);

  // events landing inside an acknowledge are parked, not lost
  assign tx_set = tx_empty_evt | tx_evt_hold_r;
  assign err_set = error_evt | err_evt_hold_r;
  assign st_set = status_evt | st_evt_hold_r;
  assign ack_win = ack_first & any_pend & chain_enable_in;

  // enable bits written from a control register write
  always @* begin
    ie_nxt = ie_r;
    if (do_wr && is_ctrl)
      ie_nxt = data_in[`IE_MSB:`IE_LSB];
  end

  // ****************************************
  // control registers, flags and commands
  // ****************************************
  always @(posedge clk) begin
    if (!nrst || both_act) begin
      vector_r <= `VECTOR_RST;
      ie_r <= `IE_RST;
      chain_dis_r <= 1'b0;
      tx_pend_r <= 1'b0;
      err_pend_r <= 1'b0;
      st_pend_r <= 1'b0;
      service_r <= 1'b0;
      tx_data <= 8'h00;
    end else begin
      ie_r <= ie_nxt;
      // vector written from channel b data select with ctrl_data_sel high
      if (do_wr && rsel == `RSEL_DATA_B)
        vector_r <= data_in;
      if (data_a_wr)
        tx_data <= data_in;
      // flags: events win over clears; frozen during acknowledge
      if (!ack_act) begin
        if (tx_set)
          tx_pend_r <= 1'b1;
        else if (data_a_wr || cmd_tx_clr)
          tx_pend_r <= 1'b0;
        if (err_set)
          err_pend_r <= 1'b1;
        else if (cmd_err_clr)
          err_pend_r <= 1'b0;
        if (st_set)
          st_pend_r <= 1'b1;
        else if (cmd_st_clr)
          st_pend_r <= 1'b0;
      end
      // under service: set by a won acknowledge, cleared by command, reset or both strobes
      if (ack_win)
        service_r <= 1'b1;
      else if (cmd_srv_clr)
        service_r <= 1'b0;
      if (cmd_chain_off)
        chain_dis_r <= 1'b1;
      else if (cmd_chain_on)
        chain_dis_r <= 1'b0;
    end
  end

  // ****************************************
  // data bus, interrupt and chain outputs
  // ****************************************
  reg [7:0] rd_mux;
  wire vec_ok;
  wire irq_req;
  // vector decided on the first acknowledge cycle, then held
  assign vec_ok = ack_rd & (ack_first ? ack_win : vec_won_r);
  assign irq_req = any_pend & ~service_r & chain_enable_in & ~both_act;

  // parked events and acknowledge history
  always @(posedge clk) begin
    if (!nrst || both_act) begin
      tx_evt_hold_r <= 1'b0;
      err_evt_hold_r <= 1'b0;
      st_evt_hold_r <= 1'b0;
      ack_seen_r <= 1'b0;
      vec_won_r <= 1'b0;
    end else begin
      tx_evt_hold_r <= ack_act & tx_set;
      err_evt_hold_r <= ack_act & err_set;
      st_evt_hold_r <= ack_act & st_set;
      ack_seen_r <= ack_rd;
      vec_won_r <= vec_ok;
    end
  end

  // read multiplexer
  always @* begin
    case (rsel)
      `RSEL_CTRL_A, `RSEL_CTRL_B: begin
        rd_mux = 8'h00;
        rd_mux[`ST_RX_AVAIL] = rx_avail;
        rd_mux[`ST_TX_EMPTY] = tx_pend_r;
        rd_mux[`ST_PENDING] = any_pend;
        rd_mux[`ST_SERVICE] = service_r;
        rd_mux[`ST_ERROR] = err_pend_r;
        rd_mux[`ST_CHAIN_DIS] = chain_dis_r;
      end
      `RSEL_DATA_A: rd_mux = rx_char;
      default: rd_mux = vector_r;
    endcase
  end

  // registered pin drivers
  always @(posedge clk) begin
    if (!nrst) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
      irq_n_out <= 1'b0;
      irq_n_oe <= 1'b0;
      chain_enable_out <= 1'b0;
      rx_read_pulse <= 1'b0;
      tx_write_pulse <= 1'b0;
      chip_reset_out <= 1'b0;
    end else begin
      chip_reset_out <= both_act;
      rx_read_pulse <= do_rd & (rsel == `RSEL_DATA_A);
      tx_write_pulse <= data_a_wr;
      if (ack_rd) begin
        data_out <= vector_r;
        data_oe <= vec_ok;
      end else if (rd_act && !wr_act && sel_ok) begin
        data_out <= rd_mux;
        data_oe <= 1'b1;
      end else begin
        data_oe <= 1'b0;
      end
      irq_n_out <= 1'b0;
      // a request may drop but never rise inside an acknowledge
      if (ack_act)
        irq_n_oe <= irq_n_oe & irq_req;
      else
        irq_n_oe <= irq_req;
      chain_enable_out <= chain_enable_in & ~service_r & ~chain_dis_r &
                          ~(ack_act & any_pend);
    end
  end

endmodule // host_port

// File: host_port_consts.vh
`ifndef HOST_PORT_CONSTS_VH
`define HOST_PORT_CONSTS_VH
// register select codes {ctrl_data_sel, chan_sel}
`define RSEL_CTRL_B 2'h0
`define RSEL_CTRL_A 2'h1
`define RSEL_DATA_B 2'h2
`define RSEL_DATA_A 2'h3
// control register write: command field positions
`define CMD_LSB 3
`define CMD_MSB 5
`define CMD_NONE 3'h0
`define CMD_RESET_TX_PEND 3'h1
`define CMD_CLEAR_SERVICE 3'h2
`define CMD_CHAIN_DISABLE 3'h3
`define CMD_CHAIN_ENABLE 3'h4
`define CMD_CLEAR_ERROR 3'h5
`define CMD_CLEAR_STATUS 3'h6
// status bits read from control register
`define ST_RX_AVAIL 0
`define ST_TX_EMPTY 2
`define ST_PENDING 4
`define ST_SERVICE 5
`define ST_ERROR 6
`define ST_CHAIN_DIS 7
// interrupt enable bits in the control register write
`define IE_LSB 0
`define IE_MSB 2
// reset values
`define VECTOR_RST 8'h00
`define IE_RST 3'h0
`endif

// File: host_port_properties.sv
`timescale 1ns/1ps
// ****
// port checks
// ****
module host_port_properties (
  input wire clk,
  input wire nrst,
  input wire chip_sel_n,
  input wire rd_n,
  input wire wr_n,
  input wire irq_acknowledge_n,
  input wire chain_enable_in,
  input wire chain_enable_out,
  input wire data_oe,
  input wire irq_n_out,
  input wire irq_n_oe,
  input wire chip_reset_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // bus, request pin and daisy link relations
  a_irq_open_drain:
  assert property (irq_n_out == 1'b0) else $error("irq pin high");
  a_bus_release:
  assert property (rd_n [*5] |-> !data_oe) else $error("bus held");
  a_read_drives:
  assert property ((!rd_n && wr_n && !chip_sel_n && irq_acknowledge_n) [*4]
    |-> data_oe) else $error("read not driven");
  a_strobe_reset:
  assert property ((!rd_n && !wr_n) [*5] |-> chip_reset_out)
    else $error("no chip reset");
  a_ack_quiet:
  assert property (!irq_acknowledge_n [*5] |-> !$rose(irq_n_oe))
    else $error("request in ack");
  a_ack_no_vector:
  assert property ((!irq_acknowledge_n && !rd_n && !chain_enable_in) [*5]
    |-> !data_oe) else $error("vector without chain");
  a_chain_blocked:
  assert property (!chain_enable_in [*3] |-> !chain_enable_out)
    else $error("chain passed");
  a_irq_chain_low:
  assert property (!chain_enable_in [*3] |-> !irq_n_oe)
    else $error("request kept");
endmodule // host_port_properties

bind host_port host_port_properties chk (.*);

// File: host_decoder.sv
`timescale 1ns/1ps
// ****
// host decode model
// ****
module host_decoder #(
  parameter io_timing_compat_bit = 1'b0
) (
  input wire [15:0] addr,
  input wire user_io_enable,
  input wire io_request_n,
  input wire cpu_rd_n,
  input wire cpu_wr_n,
  output wire serial_controller_select_n,
  output wire io_read_strobe_n,
  output wire io_write_strobe_n
);
  // select c0h..ffh in io cycles only, clear of 00h..3fh
  assign serial_controller_select_n = ~(addr[7] & addr[6] & user_io_enable &
    ~io_request_n);
  // io strobes qualified by the request; only classic timing is modelled
  assign io_read_strobe_n = io_request_n | cpu_rd_n |
    io_timing_compat_bit;
  assign io_write_strobe_n = io_request_n | cpu_wr_n |
    io_timing_compat_bit;
endmodule // host_decoder

// File: host_port_tb.sv
`timescale 1ns/1ps
// ****
// host port bench
// ****
module host_port_tb;
  reg clk, nrst, ioq_n, c_rd_n, c_wr_n, ack_n, cei, txe, rxa, o, rs;
  reg [15:0] adr;
  reg [7:0] din, q;
  wire cs_n, rd_n, wr_n, oe, ceo, ion, ioe, crst, rxp, txp;
  wire [7:0] dout, txd;
  integer fails, compares;
  integer rx_pulses = 0;
  integer tx_pulses = 0;
  host_decoder hd (.addr(adr), .user_io_enable(1'b1), .io_request_n(ioq_n),
    .cpu_rd_n(c_rd_n),
    .cpu_wr_n(c_wr_n), .serial_controller_select_n(cs_n),
    .io_read_strobe_n(rd_n), .io_write_strobe_n(wr_n));
  host_port uut (.clk(clk), .nrst(nrst), .chip_sel_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .chan_sel(adr[0]), .ctrl_data_sel(adr[1]), .data_in(din),
    .data_out(dout), .data_oe(oe), .irq_acknowledge_n(ack_n),
    .irq_n_out(ion), .irq_n_oe(ioe), .chain_enable_in(cei),
    .chain_enable_out(ceo), .tx_empty_evt(txe), .rx_avail(rxa),
    .error_evt(1'b0), .status_evt(1'b0), .rx_char(8'h3c),
    .rx_read_pulse(rxp), .tx_data(txd), .tx_write_pulse(txp),
    .chip_reset_out(crst));
  // 25 mhz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task close_out;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("ERROR %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // access: 0 read, 1 write, 2 ack read, 3 both strobes
  task acc(input [1:0] m, input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      adr <= {8'h00, a};
      din <= d;
      ioq_n <= 1'b0;
      c_rd_n <= (m == 2'h1);
      c_wr_n <= ~m[0];
      ack_n <= (m != 2'h2);
      repeat (5) @(posedge clk);
      @(negedge clk);
      q = dout;
      o = oe;
      rs = crst;
      @(posedge clk);
      ioq_n <= 1'b1;
      c_rd_n <= 1'b1;
      c_wr_n <= 1'b1;
      ack_n <= 1'b1;
      din <= ~d;
      repeat (5) @(posedge clk);
    end
  endtask
  // one transmit empty event
  task evt;
    begin
      @(posedge clk);
      txe <= 1'b1;
      @(posedge clk);
      txe <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  // tally the one-cycle strobes handed to the channels
  always @(posedge clk) begin
    if (rxp === 1'b1)
      rx_pulses <= rx_pulses + 1;
    if (txp === 1'b1)
      tx_pulses <= tx_pulses + 1;
  end
  // main sequence
  initial begin
    fails = 0;
    compares = 0;
    nrst = 1'b0;
    ioq_n = 1'b1;
    c_rd_n = 1'b1;
    c_wr_n = 1'b1;
    ack_n = 1'b1;
    cei = 1'b1;
    txe = 1'b0;
    rxa = 1'b0;
    adr = 16'h0000;
    din = 8'h00;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk({7'h00, ceo}, 8'h01);
    chk({7'h00, ion}, 8'h00);
    acc(2'h1, 8'hc2, 8'h5a);
    acc(2'h1, 8'hc1, 8'h01);
    evt;
    chk({7'h00, ioe}, 8'h01);
    acc(2'h2, 8'h00, 8'hff);
    chk(q, 8'h5a);
    chk({7'h00, o}, 8'h01);
    acc(2'h0, 8'hc1, 8'hff);
    chk(q & 8'h30, 8'h30);
    chk({7'h00, ceo}, 8'h00);
    acc(2'h1, 8'hc1, 8'h11);
    acc(2'h1, 8'hc1, 8'h09);
    acc(2'h0, 8'hc1, 8'hff);
    chk(q & 8'h30, 8'h00);
    acc(2'h1, 8'hc3, 8'ha5);
    chk(txd, 8'ha5);
    rxa <= 1'b1;
    acc(2'h0, 8'hc3, 8'hff);
    chk(q, 8'h3c);
    acc(2'h1, 8'hc1, 8'h19);
    chk({7'h00, ceo}, 8'h00);
    evt;
    cei <= 1'b0;
    acc(2'h2, 8'h00, 8'hff);
    chk({6'h00, o, ioe}, 8'h00);
    acc(2'h0, 8'hc1, 8'hff);
    chk(q & 8'h20, 8'h00);
    cei <= 1'b1;
    acc(2'h3, 8'h00, 8'hff);
    chk({7'h00, rs}, 8'h01);
    acc(2'h0, 8'hc2, 8'hff);
    chk({q[6:0], ioe}, 8'h00);
    chk(q, 8'h00);
    chk({7'h00, rs}, 8'h00);
    chk(rx_pulses[7:0], 8'h01);
    chk(tx_pulses[7:0], 8'h01);
    close_out;
  end
  // stop a hung run
  initial begin
    #100000;
    fails = fails + 1;
    close_out;
  end
endmodule // host_port_tb
